// ===== src/arsw_pkg.sv
// How it works
// R1: in both sweep modes, writing one to start begins converting input zero
// R2: finishing input zero copies the approximation result into result register zero
// R3: sweep mode 0 converts each selected input in turn, storing each result
// R4: neither sweep mode ever sets the conversion-complete interrupt request bit
// R5: sweep mode 0 repeats sweeps without pause until software clears start
// R6: sweep mode 1 runs until software clears start; hardware never clears it
// R7: sweep mode 0 groups: inputs 0-1, 0-3, 0-5 or 0-7
// R8: sweep mode 1 groups: input 0, 0-1, 0-2 or 0-3
// R9: sweep mode 1 returns to input zero after every other selected input
// R10: sweep mode 1 stores each result in the register of the converted input
// R11: one conversion takes 28 clock cycles at 8 bits, 33 at 10 bits
// R12: conversion clock is source divided by four, by two, or undivided
// R13: software must not enable sample-and-hold below a 1MHz conversion clock
// R14: mode select picks sweep mode 0 or 1, changed only while start is zero
// R15: clearing start stops the sequencer; stored results stay readable
package arsw_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RES_W = 10;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned CH_W = 3;
  localparam int unsigned CNT_W = 6;

  localparam logic [ADDR_W-1:0] CTRL_OFS = 6'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 6'h04;
  localparam logic [ADDR_W-1:0] RESULT_OFS = 6'h20;

  // control register fields
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_MODE_BIT = 1;
  localparam int unsigned CTRL_GRP_LSB = 2;
  localparam int unsigned CTRL_RES10_BIT = 4;
  localparam int unsigned CTRL_DIV_LSB = 5;
  localparam int unsigned CTRL_SH_BIT = 7;

  // status register fields
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_CH_LSB = 1;
  localparam int unsigned STAT_IRQ_BIT = 4;

  localparam logic [1:0] DIV_BY4 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY1 = 2'h2;
  localparam logic [1:0] DIV_RST = 2'h0;

  localparam logic [CNT_W-1:0] CONV_CYC_8 = 6'h1C;
  localparam logic [CNT_W-1:0] CONV_CYC_10 = 6'h21;

  localparam logic [1:0] GRP_RST = 2'h0;
  localparam logic MODE_RST = 1'b0;
  localparam logic RES10_RST = 1'b0;
  localparam logic SH_RST = 1'b0;

  typedef enum logic {ARSW_IDLE, ARSW_CONVERT} arsw_state_type;
endpackage : arsw_pkg

// ===== src/arsw_sequencer.sv
`timescale 1ns/10ps
module arsw_sequencer
  import arsw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [RES_W-1:0] sar_value,
  output logic [CH_W-1:0] analog_input_channel,
  output logic conv_active,
  output logic sample_hold_en,
  output logic conv_irq_req
);

  // last channel index of the selected group
  function automatic logic [CH_W-1:0] last_ch(input logic mode1, input logic [1:0] grp);
    logic [CH_W-1:0] r;
    r = mode1 ? {1'b0, grp} : {grp, 1'b1};
    return r;
  endfunction : last_ch

  function automatic logic [CNT_W-1:0] conv_len(input logic res10);
    return res10 ? CONV_CYC_10 : CONV_CYC_8;
  endfunction : conv_len

  arsw_state_type state_q;
  logic start_q;
  logic mode_q;
  logic [1:0] grp_q;
  logic res10_q;
  logic [1:0] div_q;
  logic sh_q;
  logic irq_q;
  logic [1:0] div_cnt_q;
  logic ad_en;
  logic [CNT_W-1:0] cnt_q;
  logic [CH_W-1:0] ch_q;
  logic [CH_W-1:0] tgt_q;
  logic [CH_W-1:0] last;
  logic busy;
  logic done;
  logic ctrl_wr;
  logic [RES_W-1:0] result_q [NUM_CH];
  logic [DATA_W-1:0] rdata_q;

  assign busy = (state_q == ARSW_CONVERT);
  assign last = last_ch(mode_q, grp_q); // [R7] [R8]
  assign ctrl_wr = reg_wr && (reg_addr == CTRL_OFS);
  assign done = busy && start_q && ad_en && (cnt_q == conv_len(res10_q) - 6'h01); // [R11]

  // conversion clock enable
  assign ad_en = (div_q == DIV_BY1) ? 1'b1 :
                 (div_q == DIV_BY2) ? div_cnt_q[0] :
                 (div_cnt_q == 2'h3); // [R12]

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      div_cnt_q <= 2'h0;
    else
      div_cnt_q <= div_cnt_q + 2'h1;
  end

  // start flag: only software changes it
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      start_q <= 1'b0;
    else if (ctrl_wr)
      start_q <= reg_wdata[CTRL_START_BIT]; // [R1] [R6]
  end

  // configuration frozen while start is set
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_q <= MODE_RST;
      grp_q <= GRP_RST;
      res10_q <= RES10_RST;
      div_q <= DIV_RST;
      sh_q <= SH_RST;
    end
    else if (ctrl_wr && !start_q)
    begin
      mode_q <= reg_wdata[CTRL_MODE_BIT]; // [R14]
      grp_q <= reg_wdata[CTRL_GRP_LSB +: 2];
      res10_q <= reg_wdata[CTRL_RES10_BIT];
      div_q <= (reg_wdata[CTRL_DIV_LSB +: 2] == 2'h3) ? DIV_BY1 : reg_wdata[CTRL_DIV_LSB +: 2];
      sh_q <= reg_wdata[CTRL_SH_BIT];
    end
  end

  // interrupt request never raised in sweep modes
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      irq_q <= 1'b0;
    else
      irq_q <= 1'b0; // [R4]
  end

  // sequencer
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ARSW_IDLE;
      cnt_q <= '0;
      ch_q <= '0;
      tgt_q <= 3'h1;
    end
    else
    begin
      case (state_q)
        ARSW_IDLE:
        begin
          if (start_q)
          begin
            state_q <= ARSW_CONVERT;
            ch_q <= '0; // [R1]
            tgt_q <= 3'h1;
            cnt_q <= '0;
          end
        end
        ARSW_CONVERT:
        begin
          if (!start_q)
          begin
            state_q <= ARSW_IDLE; // [R15]
            cnt_q <= '0;
          end
          else if (done)
          begin
            cnt_q <= '0;
            if (!mode_q)
              ch_q <= (ch_q == last) ? 3'h0 : ch_q + 3'h1; // [R3] [R5]
            else if (ch_q != 3'h0 || last == 3'h0)
              ch_q <= 3'h0; // [R9]
            else
            begin
              ch_q <= tgt_q; // [R9]
              tgt_q <= (tgt_q >= last) ? 3'h1 : tgt_q + 3'h1;
            end
          end
          else if (ad_en)
            cnt_q <= cnt_q + 6'h01;
        end
        default:
          state_q <= ARSW_IDLE;
      endcase
    end
  end

  // result registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_CH; i++)
        result_q[i] <= '0;
    end
    else if (done)
      result_q[ch_q] <= res10_q ? sar_value : {2'h0, sar_value[RES_W-1:2]}; // [R2] [R3] [R10]
  end

  // register read, data one cycle later
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= '0;
    else if (reg_rd)
    begin
      rdata_q <= '0;
      if (reg_addr == CTRL_OFS)
        rdata_q[7:0] <= {sh_q, div_q, res10_q, grp_q, mode_q, start_q};
      else if (reg_addr == STATUS_OFS)
        rdata_q[4:0] <= {irq_q, ch_q, busy};
      else if (reg_addr >= RESULT_OFS && reg_addr[1:0] == 2'h0)
        rdata_q[RES_W-1:0] <= result_q[reg_addr[4:2]];
    end
  end

  assign reg_rdata = rdata_q;
  assign analog_input_channel = ch_q;
  assign conv_active = busy;
  assign sample_hold_en = sh_q;
  assign conv_irq_req = irq_q;

  // helper: conversion clock pulses since conversion start
  logic [CNT_W-1:0] hlp_pulses_q;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      hlp_pulses_q <= '0;
    else if (!busy || done)
      hlp_pulses_q <= '0;
    else if (ad_en)
      hlp_pulses_q <= hlp_pulses_q + 6'h01;
  end

  chk_start_ch_zero: assert property (@(posedge ref_clk) disable iff (!rstn) // [R1]
    $rose(start_q) && !busy |=> busy && analog_input_channel == 3'h0)
    else $error("start did not begin on input zero");

  chk_result_zero: assert property (@(posedge ref_clk) disable iff (!rstn) // [R2]
    done && ch_q == 3'h0 && res10_q |=> result_q[0] == $past(sar_value))
    else $error("input zero result not stored");

  chk_mode0_step: assert property (@(posedge ref_clk) disable iff (!rstn) // [R3]
    done && !mode_q |=> ch_q == (($past(ch_q) == $past(last)) ? 3'h0 : $past(ch_q) + 3'h1))
    else $error("sweep mode 0 channel order wrong");

  chk_irq_quiet: assert property (@(posedge ref_clk) disable iff (!rstn) // [R4]
    !conv_irq_req)
    else $error("interrupt request raised");

  chk_sweep_continues: assert property (@(posedge ref_clk) disable iff (!rstn) // [R5]
    done |=> busy || !start_q)
    else $error("sequencer stopped with start set");

  chk_start_sw_only: assert property (@(posedge ref_clk) disable iff (!rstn) // [R6]
    $fell(start_q) |-> $past(ctrl_wr))
    else $error("start cleared by hardware");

  chk_group_range: assert property (@(posedge ref_clk) disable iff (!rstn) // [R7]
    busy |-> ch_q <= last)
    else $error("channel outside selected group");

  chk_mode1_return: assert property (@(posedge ref_clk) disable iff (!rstn) // [R9]
    done && mode_q && ch_q != 3'h0 |=> ch_q == 3'h0)
    else $error("sweep mode 1 did not return to input zero");

  chk_conv_length: assert property (@(posedge ref_clk) disable iff (!rstn) // [R11]
    done |-> hlp_pulses_q + 6'h01 == (res10_q ? 6'h21 : 6'h1C))
    else $error("conversion length wrong");

  chk_div4_spacing: assert property (@(posedge ref_clk) disable iff (!rstn) // [R12]
    div_q == DIV_BY4 && ad_en |=> (!ad_en || div_q != DIV_BY4) [*3]
    ##1 (ad_en || div_q != DIV_BY4))
    else $error("divide by four spacing wrong");

  chk_mode_frozen: assert property (@(posedge ref_clk) disable iff (!rstn) // [R14]
    busy && $past(busy) |-> $stable(mode_q))
    else $error("mode changed while converting");

  chk_stop: assert property (@(posedge ref_clk) disable iff (!rstn) // [R15]
    busy && !start_q |=> !busy ##1 (!busy || start_q))
    else $error("sequencer kept running after stop");

endmodule : arsw_sequencer

// ===== tb/arsw_sar_model.sv
`timescale 1ns/10ps
module arsw_sar_model
  import arsw_pkg::*;
(
  input wire logic [CH_W-1:0] analog_input_channel,
  output logic [RES_W-1:0] sar_value
);
  // result pattern names the converted input
  assign sar_value = {analog_input_channel, 7'h2B};
endmodule : arsw_sar_model

// ===== tb/adc_repeat_sweep_sequencer_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module adc_repeat_sweep_sequencer_bench;
  import arsw_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata, rd;
  logic [RES_W-1:0] sar_value;
  logic [CH_W-1:0] analog_input_channel, last_ch;
  logic conv_active, sample_hold_en, conv_irq_req, was_act = 1'b0, irq_seen = 1'b0;
  logic [31:0] cyc = '0;
  logic [2:0] seq[$];
  logic [31:0] stamp[$];
  int n_mismatch = 0;
  int check_count = 0;
  logic [7:0] cv[5] = '{8'hDD, 8'h2F, 8'h01, 8'h57, 8'h49};
  arsw_sequencer arsw_sequencer_i (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sar_value(sar_value), .analog_input_channel(analog_input_channel),
    .conv_active(conv_active), .sample_hold_en(sample_hold_en), .conv_irq_req(conv_irq_req));
  arsw_sar_model arsw_sar_model_i (.analog_input_channel(analog_input_channel),
    .sar_value(sar_value));
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  // records each newly converted input and when it began
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (conv_irq_req !== 1'b0) irq_seen <= 1'b1;
    if (conv_active === 1'b1 && (!was_act || analog_input_channel !== last_ch))
    begin
      seq.push_back(analog_input_channel);
      stamp.push_back(cyc);
    end
    was_act <= conv_active;
    last_ch <= analog_input_channel;
    if (cyc == 32'd20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : reg_read
  function automatic logic [2:0] exp_ch(input logic [7:0] c, input int j);
    int g;
    g = int'(c[3:2]);
    if (!c[1]) return 3'(j % (2 * g + 2));
    if (j % 2 == 0) return 3'h0;
    return 3'((((j - 1) / 2) % g) + 1);
  endfunction : exp_ch
  task automatic sweep(input logic [7:0] c);
    int per, last, n;
    per = (c[4] ? 33 : 28) * (c[6:5] == 2'h0 ? 4 : (c[6:5] == 2'h1 ? 2 : 1));
    last = c[1] ? int'(c[3:2]) : 2 * int'(c[3:2]) + 1;
    seq.delete();
    stamp.delete();
    reg_write(CTRL_OFS, {24'h0, c});
    repeat (9 * per) @(posedge ref_clk);
    reg_read(CTRL_OFS);
    `CHK(rd, {24'h0, c})
    reg_write(CTRL_OFS, {24'h0, c ^ 8'hFE});
    reg_read(CTRL_OFS);
    `CHK(rd, {24'h0, c})
    reg_read(STATUS_OFS);
    `CHK(rd & 32'h11, 32'h01)
    `CHK(sample_hold_en, c[7])
    `CHK(seq.size() >= 6, 1'b1)
    for (int j = 0; j < 6 && j < seq.size(); j++)
      `CHK(seq[j], exp_ch(c, j))
    `CHK(stamp[2] - stamp[1], 32'(per))
    reg_write(CTRL_OFS, 32'h0);
    repeat (3) @(posedge ref_clk);
    n = seq.size();
    `CHK(conv_active, 1'b0)
    repeat (4 * per) @(posedge ref_clk);
    `CHK(seq.size(), n)
    for (int i = 0; i <= last; i++)
    begin
      reg_read(RESULT_OFS + 6'(4 * i));
      `CHK(rd, c[4] ? {22'h0, 3'(i), 7'h2B} : {24'h0, 3'(i), 5'h0A})
    end
  endtask : sweep
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    reg_read(CTRL_OFS);
    `CHK(rd, 32'h0)
    reg_read(STATUS_OFS);
    `CHK(rd, 32'h0)
    reg_write(6'h08, 32'hFFFF_FFFF);
    reg_read(6'h08);
    `CHK(rd, 32'h0)
    foreach (cv[k]) sweep(cv[k]);
    `CHK(irq_seen, 1'b0)
    complete_run();
  end
endmodule : adc_repeat_sweep_sequencer_bench
